// *** rtl/compare_channel.v ***
// One output compare channel with its output pin
`timescale 1ns/1ps
module compare_channel #(
   parameter CNT_W = 16
) (
   input wire core_clk,
   input wire srst,
   input wire tick,
   input wire [CNT_W-1:0] count,
   input wire [CNT_W-1:0] value,
   input wire toggle_en,
   output wire match,
   output reg pin_out
);
   assign match = tick & (count == value);

   always @(posedge core_clk) begin
      if (srst) begin
         pin_out <= 1'b0;
      end else if (match && toggle_en) begin
         pin_out <= ~pin_out;
      end
   end
endmodule // compare_channel

// *** rtl/edge_sync.v ***
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module edge_sync (
   input wire core_clk,
   input wire srst,
   input wire pin_in,
   input wire rise_sel,
   output reg edge_pulse
);
   reg sync1_r;
   reg sync2_r;
   reg prev_r;

   always @(posedge core_clk) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         // One-cycle pulse on the chosen edge
         if (rise_sel) begin
            edge_pulse <= sync2_r & ~prev_r;
         end else begin
            edge_pulse <= ~sync2_r & prev_r;
         end
      end
   end
endmodule // edge_sync

// *** rtl/free_running_timer.v ***
// Free running timer with two compare channels and four capture inputs
`timescale 1ns/1ps
`include "frt_defines.vh"

module free_running_timer #(
   parameter ADDR_W = 8,
   parameter CNT_W = 16
) (
   input wire core_clk,
   input wire srst,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire event_in,
   input wire [3:0] capture_in,
   output wire compare_out_a,
   output wire compare_out_b,
   output wire irq
);
   localparam NUM_CAP = 4;

   // Register address match
   function addr_hit;
      input [ADDR_W-1:0] addr;
      input [7:0] ofs;
      begin
         addr_hit = (addr[7:2] == ofs[7:2]);
      end
   endfunction

   // Prescaler mask for the selected division
   function [`FRT_PRESC_W-1:0] div_mask;
      input [1:0] sel;
      begin
         case (sel)
            2'd0: div_mask = `FRT_DIV_MASK0;
            2'd1: div_mask = `FRT_DIV_MASK1;
            2'd2: div_mask = `FRT_DIV_MASK2;
            2'd3: div_mask = `FRT_DIV_MASK3;
            default: div_mask = `FRT_DIV_MASK0;
         endcase
      end
   endfunction

   reg [`FRT_CTRL_W-1:0] ctrl_r;
   reg [`FRT_IRQ_W-1:0] status_r;
   reg [`FRT_IRQ_W-1:0] status_nxt;
   reg [`FRT_IRQ_W-1:0] irq_en_r;
   reg [CNT_W-1:0] count_r;
   reg [CNT_W-1:0] count_nxt;
   reg [CNT_W-1:0] cmp_a_r;
   reg [CNT_W-1:0] cmp_b_r;
   reg [NUM_CAP*CNT_W-1:0] cap_r;
   reg [`FRT_PRESC_W-1:0] presc_r;
   reg [31:0] rdata_r;
   reg [31:0] rd_mux;
   reg wr_pend_r;
   reg [ADDR_W-1:0] wr_addr_r;

   wire bus_go;
   wire wr_ctrl;
   wire wr_status;
   wire wr_irq_en;
   wire wr_count;
   wire wr_cmp_a;
   wire wr_cmp_b;
   wire event_pulse;
   wire [NUM_CAP-1:0] cap_pulse;
   wire [`FRT_PRESC_W-1:0] presc_mask;
   wire timer_tick;
   wire tick;
   wire match_a;
   wire match_b;
   wire clear_hit;
   wire overflow;
   wire [`FRT_IRQ_W-1:0] status_set;
   wire [`FRT_IRQ_W-1:0] status_clr;

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;
   assign bus_go = hsel & htrans[1] & hready;

   // Write pending for the data phase
   always @(posedge core_clk) begin
      if (srst) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= bus_go & hwrite;
      end
   end

   // Address of the transfer in its data phase
   always @(posedge core_clk) begin
      if (srst) begin
         wr_addr_r <= {ADDR_W{1'b0}};
      end else if (bus_go) begin
         wr_addr_r <= haddr;
      end
   end

   assign wr_ctrl = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_CTRL);
   assign wr_status = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_STATUS);
   assign wr_irq_en = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_IRQ_EN);
   assign wr_count = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_COUNT);
   assign wr_cmp_a = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_CMP_A);
   assign wr_cmp_b = wr_pend_r & addr_hit(wr_addr_r, `FRT_OFS_CMP_B);

   // Read mux, sampled in the address phase
   always @* begin
      rd_mux = 32'h00000000;
      case (1'b1)
         addr_hit(haddr, `FRT_OFS_CTRL): begin
            rd_mux[`FRT_CTRL_W-1:0] = ctrl_r;
         end
         addr_hit(haddr, `FRT_OFS_STATUS): begin
            rd_mux[`FRT_IRQ_W-1:0] = status_r;
         end
         addr_hit(haddr, `FRT_OFS_IRQ_EN): begin
            rd_mux[`FRT_IRQ_W-1:0] = irq_en_r;
         end
         addr_hit(haddr, `FRT_OFS_COUNT): begin
            rd_mux[CNT_W-1:0] = count_r;
         end
         addr_hit(haddr, `FRT_OFS_CMP_A): begin
            rd_mux[CNT_W-1:0] = cmp_a_r;
         end
         addr_hit(haddr, `FRT_OFS_CMP_B): begin
            rd_mux[CNT_W-1:0] = cmp_b_r;
         end
         addr_hit(haddr, `FRT_OFS_CAP0): begin
            rd_mux[CNT_W-1:0] = cap_r[0*CNT_W +: CNT_W];
         end
         addr_hit(haddr, `FRT_OFS_CAP1): begin
            rd_mux[CNT_W-1:0] = cap_r[1*CNT_W +: CNT_W];
         end
         addr_hit(haddr, `FRT_OFS_CAP2): begin
            rd_mux[CNT_W-1:0] = cap_r[2*CNT_W +: CNT_W];
         end
         addr_hit(haddr, `FRT_OFS_CAP3): begin
            rd_mux[CNT_W-1:0] = cap_r[3*CNT_W +: CNT_W];
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (srst) begin
         rdata_r <= 32'h00000000;
      end else if (bus_go && !hwrite) begin
         rdata_r <= rd_mux;
      end
   end

   // Control register
   always @(posedge core_clk) begin
      if (srst) begin
         ctrl_r <= `FRT_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= hwdata[`FRT_CTRL_W-1:0];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         irq_en_r <= `FRT_IRQ_EN_RST;
      end else if (wr_irq_en) begin
         irq_en_r <= hwdata[`FRT_IRQ_W-1:0];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         cmp_a_r <= `FRT_CMP_RST;
      end else if (wr_cmp_a) begin
         cmp_a_r <= hwdata[CNT_W-1:0];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         cmp_b_r <= `FRT_CMP_RST;
      end else if (wr_cmp_b) begin
         cmp_b_r <= hwdata[CNT_W-1:0];
      end
   end

   // prescaler, divide by two at least
   always @(posedge core_clk) begin
      if (srst) begin
         presc_r <= {`FRT_PRESC_W{1'b0}};
      end else begin
         presc_r <= presc_r + {{(`FRT_PRESC_W-1){1'b0}}, 1'b1};
      end
   end

   assign presc_mask = div_mask(ctrl_r[`FRT_C_DIV_HI:`FRT_C_DIV_LO]);
   assign timer_tick = ((presc_r & presc_mask) == presc_mask);

   edge_sync u_event_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(event_in),
      .rise_sel(ctrl_r[`FRT_C_EVT_RISE]),
      .edge_pulse(event_pulse)
   );

   // timer mode or event counter mode
   assign tick = ctrl_r[`FRT_C_MODE] ? event_pulse : timer_tick;

   compare_channel #(
      .CNT_W(CNT_W)
   ) u_cmp_a (
      .core_clk(core_clk),
      .srst(srst),
      .tick(tick),
      .count(count_r),
      .value(cmp_a_r),
      .toggle_en(ctrl_r[`FRT_C_TGL_A]),
      .match(match_a),
      .pin_out(compare_out_a)
   );

   compare_channel #(
      .CNT_W(CNT_W)
   ) u_cmp_b (
      .core_clk(core_clk),
      .srst(srst),
      .tick(tick),
      .count(count_r),
      .value(cmp_b_r),
      .toggle_en(ctrl_r[`FRT_C_TGL_B]),
      .match(match_b),
      .pin_out(compare_out_b)
   );

   assign clear_hit = (match_a & ctrl_r[`FRT_C_CLR_A]) | (match_b & ctrl_r[`FRT_C_CLR_B]);
   assign overflow = tick & ~clear_hit & (&count_r);

   // counter update; a software load wins
   always @* begin
      count_nxt = count_r;
      if (tick) begin
         if (clear_hit) begin
            count_nxt = {CNT_W{1'b0}};
         end else begin
            count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
      if (wr_count) begin
         count_nxt = hwdata[CNT_W-1:0];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         count_r <= {CNT_W{1'b0}};
      end else begin
         count_r <= count_nxt;
      end
   end

   // Capture inputs
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CAP; gi = gi + 1) begin : g_cap
         edge_sync u_cap_sync (
            .core_clk(core_clk),
            .srst(srst),
            .pin_in(capture_in[gi]),
            .rise_sel(ctrl_r[`FRT_C_CAP_LO + gi]),
            .edge_pulse(cap_pulse[gi])
         );
      end
   endgenerate

   integer ci;
   always @(posedge core_clk) begin
      if (srst) begin
         cap_r <= {(NUM_CAP*CNT_W){1'b0}};
      end else begin
         for (ci = 0; ci < NUM_CAP; ci = ci + 1) begin
            if (cap_pulse[ci]) begin
               cap_r[ci*CNT_W +: CNT_W] <= count_r;
            end
         end
      end
   end

   assign status_set = {overflow, cap_pulse, match_b, match_a};
   assign status_clr = wr_status ? hwdata[`FRT_IRQ_W-1:0] : {`FRT_IRQ_W{1'b0}};

   always @* begin
      status_nxt = (status_r & ~status_clr) | status_set;
   end

   always @(posedge core_clk) begin
      if (srst) begin
         status_r <= {`FRT_IRQ_W{1'b0}};
      end else begin
         status_r <= status_nxt;
      end
   end

   assign irq = |(status_r & irq_en_r);

endmodule // free_running_timer

// *** rtl/frt_defines.vh ***
// Offsets, field positions, reset values and timing counts of the free running timer
`ifndef FRT_DEFINES_VH
`define FRT_DEFINES_VH

// Register byte offsets
`define FRT_OFS_CTRL 8'h00
`define FRT_OFS_STATUS 8'h04
`define FRT_OFS_IRQ_EN 8'h08
`define FRT_OFS_COUNT 8'h0c
`define FRT_OFS_CMP_A 8'h10
`define FRT_OFS_CMP_B 8'h14
`define FRT_OFS_CAP0 8'h18
`define FRT_OFS_CAP1 8'h1c
`define FRT_OFS_CAP2 8'h20
`define FRT_OFS_CAP3 8'h24

// Control register fields
`define FRT_C_MODE 0
`define FRT_C_DIV_LO 1
`define FRT_C_DIV_HI 2
`define FRT_C_EVT_RISE 3
`define FRT_C_CAP_LO 4
`define FRT_C_CAP_HI 7
`define FRT_C_CLR_A 8
`define FRT_C_CLR_B 9
`define FRT_C_TGL_A 10
`define FRT_C_TGL_B 11
`define FRT_CTRL_W 12

// Status and interrupt enable fields
`define FRT_S_CMP_A 0
`define FRT_S_CMP_B 1
`define FRT_S_CAP_LO 2
`define FRT_S_CAP_HI 5
`define FRT_S_OVF 6
`define FRT_IRQ_W 7

// Reset values
`define FRT_CTRL_RST 12'h000
`define FRT_IRQ_EN_RST 7'h00
`define FRT_CMP_RST 16'hffff

// Fastest tick: 200 ns at a 10 MHz reference clock
`define FRT_FASTEST_NS 200
`define FRT_REF_CLK_MHZ 10
`define FRT_MIN_DIV (`FRT_FASTEST_NS * `FRT_REF_CLK_MHZ / 1000)

// Prescaler masks for divide by 2, 8, 32 and 128
`define FRT_PRESC_W 7
`define FRT_DIV_MASK0 7'h01
`define FRT_DIV_MASK1 7'h07
`define FRT_DIV_MASK2 7'h1f
`define FRT_DIV_MASK3 7'h7f

`endif

// *** tb/pin_stim.sv ***
// Model of the event and capture pin sources
`timescale 1ns/1ps
module pin_stim (
   input wire core_clk,
   output wire event_in,
   output wire [3:0] capture_in
);
   logic [4:0] lines = 5'h00;
   assign event_in = lines[4];
   assign capture_in = lines[3:0];
   // Pulse long enough for the two-stage synchroniser
   task pulse(input int n);
      lines[n] <= 1'b1;
      repeat (4) @(posedge core_clk);
      lines[n] <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
endmodule // pin_stim

// *** tb/tb_free_running_timer.sv ***
// Self-checking testbench of the free running timer
`timescale 1ns/1ps
module tb_free_running_timer;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rdv;
   logic [31:0] d0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, event_in, compare_out_a, compare_out_b, irq;
   wire [3:0] capture_in;
   int num_errors = 0;
   int n_checks = 0;
   int i;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h28};
   logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0};

   always #2.5 core_clk = ~core_clk;

   free_running_timer dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
      .capture_in(capture_in), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
      .irq(irq));
   pin_stim pins (.core_clk(core_clk), .event_in(event_in), .capture_in(capture_in));

   task chk(input [31:0] got, input [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_rdy;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
   endtask
   task xfer(input logic w, input [7:0] a, input [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rdv = hrdata;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   task chk_irq(input logic e);
      @(negedge core_clk);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge core_clk);
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #50000;
      num_errors++;
      end_sim;
   end

   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
      xfer(1'b0, 8'h0c, 32'h0);
      d0 = rdv;
      xfer(1'b0, 8'h0c, 32'h0);
      chk(rdv - d0, 32'h1);
      $display("test reset and rate done");
      xfer(1'b1, 8'h10, 32'h5);
      xfer(1'b1, 8'h08, 32'h1);
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b1, 8'h00, 32'h500);
      i = 0;
      while (irq !== 1'b1 && i < 200) begin
         @(posedge core_clk);
         i++;
      end
      @(negedge core_clk);
      chk({30'h0, compare_out_b, compare_out_a}, 32'h1);
      @(posedge core_clk);
      chk_irq(1'b1);
      xfer(1'b0, 8'h0c, 32'h0);
      chk({31'h0, rdv <= 32'h5}, 32'h1);
      rd(8'h04, 32'h1);
      xfer(1'b1, 8'h08, 32'h0);
      chk_irq(1'b0);
      $display("test compare done");
      xfer(1'b1, 8'h00, 32'hf1);
      xfer(1'b1, 8'h04, 32'h7f);
      xfer(1'b1, 8'h0c, 32'h1234);
      for (i = 0; i < 4; i++) begin
         pins.pulse(i);
         rd(8'(8'h18 + 4 * i), 32'h1234);
      end
      rd(8'h04, 32'h3c);
      chk_irq(1'b0);
      xfer(1'b1, 8'h08, 32'h3c);
      chk_irq(1'b1);
      xfer(1'b1, 8'h04, 32'h3c);
      chk_irq(1'b0);
      $display("test capture done");
      xfer(1'b1, 8'h00, 32'hf9);
      xfer(1'b1, 8'h08, 32'h40);
      xfer(1'b1, 8'h0c, 32'hfffe);
      pins.pulse(4);
      pins.pulse(4);
      rd(8'h0c, 32'h0);
      rd(8'h04, 32'h42);
      chk_irq(1'b1);
      xfer(1'b1, 8'h04, 32'h40);
      rd(8'h04, 32'h2);
      chk_irq(1'b0);
      $display("test overflow done");
      end_sim;
   end
endmodule // tb_free_running_timer

// *** tb/timer_checker.sv ***
// Port-level assertions for the free running timer
`timescale 1ns/1ps
module timer_checker (
   input wire core_clk,
   input wire srst,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire compare_out_a,
   input wire compare_out_b,
   input wire irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence rst_done;
      $fell(srst);
   endsequence
   sequence no_read;
      !(hsel && htrans[1] && hready && !hwrite);
   endsequence
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_pins_reset: assert property (rst_done |-> !compare_out_a && !compare_out_b)
      else $error("pins not low after reset");
   a_irq_reset: assert property (rst_done |-> !irq ##1 !irq)
      else $error("irq high after reset");
   a_rdata_reset: assert property (rst_done |-> hrdata == 32'h0)
      else $error("hrdata not zero after reset");
   a_rdata_hold: assert property (no_read |=> $stable(hrdata))
      else $error("hrdata changed without read");
   a_gap_pin_a: assert property ($changed(compare_out_a) |=> $stable(compare_out_a))
      else $error("pin a toggled twice in a row");
   a_gap_pin_b: assert property ($changed(compare_out_b) |=> $stable(compare_out_b))
      else $error("pin b toggled twice in a row");
endmodule // timer_checker

bind free_running_timer timer_checker u_chk (.core_clk(core_clk), .srst(srst), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b), .irq(irq));
